// file: csrs_pkg.sv
// Contract
// - Selected chip acknowledges every write byte, then awaits next eight bits.
// - Data byte loads into addressed register on clock fall after eighth bit.
// - After a write byte acknowledge the pointer advances to next register.
// - Pointer advancing past highest register returns to register zero.
// - After acknowledging read slave byte, chip drives one bit per master clock.
// - After eighth read bit the pointer advances; acknowledge fetches next register.
// - Read slave byte alone returns data from the present pointer.
// - Lower chip answers 0101000, upper 0101001, direction bit last.
// - Lower chip passes bus bits to cascade port with no delay.
// - Only the matching chip acknowledges; the other ignores traffic until stop.
// - Lower chip keeps relaying traffic while ignoring it itself.
// - Cascade link: one clock lower to upper, one data line each way.
// - After power-up the three configuration registers reject writes until unlocked.
// - Unlock register holds the bits that unlock the configuration registers.
// - Unlock bit 7 opens register 7, bit 6 register 6, bit 5 register 5.
// - Clearing an unlock bit protects its configuration register again.
// - Every byte travels most significant bit first.
// - In read mode the chip stops sending when no acknowledge follows a byte.
// - Chip refuses a foreign slave byte, acknowledges all other address and data bytes.
package csrs_pkg;
	localparam logic [6:0] SLAVE_LOWER           = 7'h28;
	localparam logic [6:0] SLAVE_UPPER           = 7'h29;
	localparam int         NUM_REGS              = 11;
	localparam logic [3:0] REG_LAST              = 4'hA;
	localparam logic [3:0] ADDR_DISCHARGE        = 4'h5;
	localparam logic [3:0] ADDR_CHARGE           = 4'h6;
	localparam logic [3:0] ADDR_FEATURE          = 4'h7;
	localparam logic [3:0] ADDR_UNLOCK           = 4'h8;
	localparam int         BIT_DISCHARGE_UNLOCK  = 5;
	localparam int         BIT_CHARGE_UNLOCK     = 6;
	localparam int         BIT_FEATURE_UNLOCK    = 7;
	localparam logic [7:0] REG_RESET             = 8'h00;
	localparam logic [7:0] UNLOCK_RESET          = 8'h00;
	localparam logic [3:0] PTR_RESET             = 4'h0;
	localparam logic [3:0] BITS_PER_BYTE         = 4'h8;
	localparam logic [3:0] CNT_RESET             = 4'h0;
	localparam int         CFG_WIDTH             = 32;

	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_SLV  = 10'h002,
		ST_SACK = 10'h004,
		ST_RA   = 10'h008,
		ST_AACK = 10'h010,
		ST_WR   = 10'h020,
		ST_WACK = 10'h040,
		ST_RD   = 10'h080,
		ST_MACK = 10'h100,
		ST_IGN  = 10'h200
	} csrs_state_t;
endpackage

// file: csrs_word_sync.sv
`timescale 1ns/1ns
module csrs_word_sync #(
	parameter int WIDTH = 32
) (
	input  wire logic             src_clk,
	input  wire logic             src_rst_n,
	input  wire logic [WIDTH-1:0] src_data,
	input  wire logic             dst_clk,
	input  wire logic             dst_rst_n,
	output logic      [WIDTH-1:0] dst_data,
	output logic                  dst_valid
);
	logic [WIDTH-1:0] hold_reg;
	logic             req_reg;
	logic             busy_reg;
	logic             ack_s1_reg;
	logic             ack_s2_reg;
	logic             req_s1_reg;
	logic             req_s2_reg;
	logic             req_d_reg;
	logic [WIDTH-1:0] out_reg;
	logic             valid_reg;

	wire launch = !busy_reg && (src_data != hold_reg);
	wire done   = busy_reg && (ack_s2_reg == req_reg);
	wire arrive = req_s2_reg != req_d_reg;

	// Held word stays stable until the far side echoes the toggle
	always_ff @(posedge src_clk or negedge src_rst_n) begin
		if (!src_rst_n) begin
			hold_reg   <= '0;
			req_reg    <= 1'b0;
			busy_reg   <= 1'b0;
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
		end else begin
			ack_s1_reg <= req_d_reg;
			ack_s2_reg <= ack_s1_reg;
			if (launch) begin
				hold_reg <= src_data;
				req_reg  <= ~req_reg;
				busy_reg <= 1'b1;
			end else if (done) begin
				busy_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge dst_clk or negedge dst_rst_n) begin
		if (!dst_rst_n) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_d_reg  <= 1'b0;
			out_reg    <= '0;
			valid_reg  <= 1'b0;
		end else begin
			req_s1_reg <= req_reg;
			req_s2_reg <= req_s1_reg;
			req_d_reg  <= req_s2_reg;
			valid_reg  <= arrive;
			if (arrive) begin
				out_reg <= hold_reg;
			end
		end
	end

	assign dst_data  = out_reg;
	assign dst_valid = valid_reg;
endmodule

// file: csrs_top.sv
`timescale 1ns/1ns
module csrs_top #(
	parameter logic [6:0] SLAVE_ADDR = csrs_pkg::SLAVE_LOWER
) (
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       link_clk,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic            cascade_clock_out,
	output logic            lower_cascade_data_out,
	input  wire logic       lower_cascade_data_in,
	output logic [7:0]      discharge_settings,
	output logic [7:0]      charge_settings,
	output logic [7:0]      feature_settings,
	output logic [7:0]      config_write_unlock,
	output logic            config_update
);
	import csrs_pkg::*;

	logic        sys_rst_s1_reg;
	logic        sys_rst_n_reg;
	logic        rst_s1_reg;
	logic        link_rst_n_reg;
	logic        scl_s1_reg;
	logic        scl_s2_reg;
	logic        scl_d_reg;
	logic        sda_s1_reg;
	logic        sda_s2_reg;
	logic        sda_d_reg;
	logic        cas_s1_reg;
	logic        cas_s2_reg;
	csrs_state_t st_reg;
	csrs_state_t st_next;
	logic [3:0]  cnt_reg;
	logic [3:0]  cnt_next;
	logic [7:0]  sr_reg;
	logic [7:0]  sr_next;
	logic [3:0]  ptr_reg;
	logic [3:0]  ptr_next;
	logic [7:0]  tx_reg;
	logic [7:0]  tx_next;
	logic        low_reg;
	logic        low_next;
	logic        rw_reg;
	logic        rw_next;
	logic        acked_reg;
	logic        acked_next;
	logic [7:0]  regs [0:NUM_REGS-1];
	logic [CFG_WIDTH-1:0] cfg_word;
	logic [CFG_WIDTH-1:0] cfg_sync;

	function automatic logic [3:0] ptr_inc(input logic [3:0] p);
		ptr_inc = (p >= REG_LAST) ? PTR_RESET : p + 4'h1;
	endfunction

	function automatic logic wr_allowed(input logic [3:0] p, input logic [7:0] unl);
		case (p)
			ADDR_DISCHARGE: wr_allowed = unl[BIT_DISCHARGE_UNLOCK];
			ADDR_CHARGE:    wr_allowed = unl[BIT_CHARGE_UNLOCK];
			ADDR_FEATURE:   wr_allowed = unl[BIT_FEATURE_UNLOCK];
			default:        wr_allowed = (p <= REG_LAST);
		endcase
	endfunction

	// Link-side reset: asserts at once, releases on the link clock
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_reg     <= 1'b0;
			link_rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg     <= 1'b1;
			link_rst_n_reg <= rst_s1_reg;
		end
	end

	// System-side reset: asserts at once, releases on the system clock
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sys_rst_s1_reg <= 1'b0;
			sys_rst_n_reg  <= 1'b0;
		end else begin
			sys_rst_s1_reg <= 1'b1;
			sys_rst_n_reg  <= sys_rst_s1_reg;
		end
	end

	// Bus and cascade pin synchronisers
	always_ff @(posedge link_clk or negedge link_rst_n_reg) begin
		if (!link_rst_n_reg) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_d_reg  <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_d_reg  <= 1'b1;
			cas_s1_reg <= 1'b1;
			cas_s2_reg <= 1'b1;
		end else begin
			scl_s1_reg <= scl_in;
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg  <= scl_s2_reg;
			sda_s1_reg <= sda_in;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg  <= sda_s2_reg;
			cas_s1_reg <= lower_cascade_data_in;
			cas_s2_reg <= cas_s1_reg;
		end
	end

	wire       scl_rise   = scl_s2_reg & ~scl_d_reg;
	wire       scl_fall   = ~scl_s2_reg & scl_d_reg;
	wire       scl_high   = scl_s2_reg & scl_d_reg;
	wire       start_det  = scl_high & sda_d_reg & ~sda_s2_reg;
	wire       stop_det   = scl_high & ~sda_d_reg & sda_s2_reg;
	wire       byte_done  = scl_fall && (cnt_reg == BITS_PER_BYTE);
	wire       addr_match = sr_reg[7:1] == SLAVE_ADDR;
	wire       wr_fire    = (st_reg == ST_WR) && byte_done;
	wire       wr_en      = wr_fire && wr_allowed(ptr_reg, regs[ADDR_UNLOCK]);
	wire [7:0] rd_data    = (ptr_reg <= REG_LAST) ? regs[ptr_reg] : REG_RESET;
	wire [7:0] dis_q      = regs[ADDR_DISCHARGE];
	wire [7:0] feat_q     = regs[ADDR_FEATURE];
	wire [7:0] unlock_q   = regs[ADDR_UNLOCK];

	always_comb begin
		st_next    = st_reg;
		cnt_next   = cnt_reg;
		sr_next    = sr_reg;
		ptr_next   = ptr_reg;
		tx_next    = tx_reg;
		low_next   = low_reg;
		rw_next    = rw_reg;
		acked_next = acked_reg;
		if (stop_det) begin
			st_next  = ST_IDLE;
			low_next = 1'b0;
		end else if (start_det && st_reg != ST_IGN) begin
			st_next  = ST_SLV;
			cnt_next = CNT_RESET;
			low_next = 1'b0;
		end else if (scl_rise) begin
			sr_next    = {sr_reg[6:0], sda_s2_reg};
			cnt_next   = cnt_reg + 4'h1;
			acked_next = ~sda_s2_reg;
		end else if (scl_fall) begin
			case (st_reg)
				ST_SLV: begin
					if (byte_done) begin
						rw_next = sr_reg[0];
						if (addr_match) begin
							st_next  = ST_SACK;
							low_next = 1'b1;
						end else begin
							st_next = ST_IGN;
						end
					end
				end
				ST_SACK: begin
					cnt_next = CNT_RESET;
					if (rw_reg) begin
						st_next  = ST_RD;
						tx_next  = rd_data;
						low_next = ~rd_data[7];
					end else begin
						st_next  = ST_RA;
						low_next = 1'b0;
					end
				end
				ST_RA: begin
					if (byte_done) begin
						ptr_next = sr_reg[3:0];
						st_next  = ST_AACK;
						low_next = 1'b1;
					end
				end
				ST_AACK: begin
					cnt_next = CNT_RESET;
					st_next  = ST_WR;
					low_next = 1'b0;
				end
				ST_WR: begin
					if (byte_done) begin
						st_next  = ST_WACK;
						low_next = 1'b1;
					end
				end
				ST_WACK: begin
					cnt_next = CNT_RESET;
					st_next  = ST_WR;
					low_next = 1'b0;
					ptr_next = ptr_inc(ptr_reg);
				end
				ST_RD: begin
					if (byte_done) begin
						st_next  = ST_MACK;
						low_next = 1'b0;
						ptr_next = ptr_inc(ptr_reg);
					end else begin
						tx_next  = {tx_reg[6:0], 1'b0};
						low_next = ~tx_reg[6];
					end
				end
				ST_MACK: begin
					if (acked_reg) begin
						st_next  = ST_RD;
						cnt_next = CNT_RESET;
						tx_next  = rd_data;
						low_next = ~rd_data[7];
					end else begin
						st_next  = ST_IDLE;
						low_next = 1'b0;
					end
				end
				default: begin
					st_next  = (st_reg == ST_IGN) ? ST_IGN : ST_IDLE;
					low_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge link_rst_n_reg) begin
		if (!link_rst_n_reg) begin
			st_reg    <= ST_IDLE;
			cnt_reg   <= CNT_RESET;
			sr_reg    <= REG_RESET;
			ptr_reg   <= PTR_RESET;
			tx_reg    <= REG_RESET;
			low_reg   <= 1'b0;
			rw_reg    <= 1'b0;
			acked_reg <= 1'b0;
		end else begin
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			sr_reg    <= sr_next;
			ptr_reg   <= ptr_next;
			tx_reg    <= tx_next;
			low_reg   <= low_next;
			rw_reg    <= rw_next;
			acked_reg <= acked_next;
		end
	end

	// Register map; unlock register gates the three configuration registers
	always_ff @(posedge link_clk or negedge link_rst_n_reg) begin
		if (!link_rst_n_reg) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= (i == int'(ADDR_UNLOCK)) ? UNLOCK_RESET : REG_RESET;
			end
		end else if (wr_en) begin
			regs[ptr_reg] <= sr_reg;
		end
	end

	// Cascade relay: bus wires pass straight through, upper chip pulls bus low
	assign cascade_clock_out      = scl_in;
	assign lower_cascade_data_out = sda_in;
	assign sda_out                = 1'b0;
	assign sda_oe                 = low_reg | ~cas_s2_reg;

	assign cfg_word = {dis_q, regs[ADDR_CHARGE], feat_q, unlock_q};

	csrs_word_sync #(
		.WIDTH(CFG_WIDTH)
	) u_cfg_sync (
		.src_clk  (link_clk),
		.src_rst_n(link_rst_n_reg),
		.src_data (cfg_word),
		.dst_clk  (mclk),
		.dst_rst_n(sys_rst_n_reg),
		.dst_data (cfg_sync),
		.dst_valid(config_update)
	);

	assign discharge_settings  = cfg_sync[31:24];
	assign charge_settings     = cfg_sync[23:16];
	assign feature_settings    = cfg_sync[15:8];
	assign config_write_unlock = cfg_sync[7:0];

	a_ack_on_match: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(st_reg == ST_SLV && byte_done && addr_match && !stop_det && !start_det)
		|=> (low_reg && st_reg == ST_SACK))
		else $error("matching slave byte not acknowledged");

	a_foreign_refused: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(st_reg == ST_SLV && byte_done && !addr_match && !stop_det && !start_det)
		|=> (!low_reg && st_reg == ST_IGN))
		else $error("foreign slave byte acknowledged");

	a_ignore_to_stop: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(st_reg == ST_IGN && !stop_det) |=> (st_reg == ST_IGN && !low_reg))
		else $error("ignoring chip left before stop");

	a_ptr_wraps: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(st_reg == ST_WACK && scl_fall && ptr_reg == REG_LAST && !stop_det && !start_det)
		|=> (ptr_reg == PTR_RESET))
		else $error("pointer did not wrap to zero");

	a_locked_unchanged: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(wr_fire && ptr_reg == ADDR_DISCHARGE && !unlock_q[BIT_DISCHARGE_UNLOCK] && !stop_det && !start_det)
		|=> ($stable(dis_q) && st_reg == ST_WACK && low_reg))
		else $error("protected register changed or write not acknowledged");

	a_unlocked_loads: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(wr_fire && ptr_reg == ADDR_FEATURE && unlock_q[BIT_FEATURE_UNLOCK] && !stop_det && !start_det)
		|=> (feat_q == $past(sr_reg)))
		else $error("unlocked register did not load data byte");

	a_read_advance: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(st_reg == ST_RD && byte_done && !stop_det && !start_det)
		|=> (ptr_reg == ptr_inc($past(ptr_reg)) && st_reg == ST_MACK && !low_reg))
		else $error("read pointer did not advance after eighth bit");

	a_nack_ends_read: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(st_reg == ST_MACK && scl_fall && !acked_reg && !stop_det && !start_det)
		|=> (!low_reg)[*4])
		else $error("data driven after missing acknowledge");

	a_relay_in_ignore: assert property (@(posedge link_clk) disable iff (!link_rst_n_reg)
		(st_reg == ST_IGN) |-> (lower_cascade_data_out == sda_in && cascade_clock_out == scl_in))
		else $error("relay interrupted while ignoring");

	a_reset_state: assert property (@(posedge link_clk)
		$rose(link_rst_n_reg) |-> (unlock_q == UNLOCK_RESET && ptr_reg == PTR_RESET))
		else $error("unlock bits or pointer not cleared by reset");
endmodule

// file: csrs_bus_master.sv
`timescale 1ns/1ns
module csrs_bus_master (
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// One bit; data moves only while the clock is low
	task automatic clk_bit(input logic b, output logic r);
		@(posedge mclk) scl <= 1'b0;
		@(posedge mclk) sda_low <= !b;
		@(posedge mclk) scl <= 1'b1;
		@(posedge mclk) r = sda;
	endtask
	task automatic start();
		@(posedge mclk) scl <= 1'b0;
		@(posedge mclk) sda_low <= 1'b0;
		@(posedge mclk) scl <= 1'b1;
		@(posedge mclk) sda_low <= 1'b1;
	endtask
	task automatic stop();
		@(posedge mclk) scl <= 1'b0;
		@(posedge mclk) sda_low <= 1'b1;
		@(posedge mclk) scl <= 1'b1;
		@(posedge mclk) sda_low <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], r);
		end
		clk_bit(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, d[i]);
		end
		clk_bit(last, r);
	endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import csrs_pkg::*;
	logic        mclk;
	logic        link_clk;
	logic        resetn;
	logic        cas_in;
	logic        scl;
	logic        m_low;
	logic        sda_oe;
	logic        cas_clk;
	logic        cas_dat;
	logic [7:0]  dis_q;
	logic [7:0]  chg_q;
	logic [7:0]  fea_q;
	logic [7:0]  unl_q;
	wire         sda;
	logic        sda_o;
	logic        cfg_upd;
	logic [31:0] cfg_mark;
	int          upd_mark;
	int          n_upd;
	logic [7:0]  exp_reg [0:10];
	logic [7:0]  wq [$];
	logic [7:0]  pat [4] = '{8'hE0, 8'h60, 8'hA0, 8'hC0};
	logic [3:0]  ptr;
	logic [31:0] seed;
	logic        ack;
	int          n_errors;
	int          cmp_count;
	assign sda = !((sda_oe && !sda_o) || m_low);
	initial mclk = 1'b0;
	always #25 mclk = !mclk;
	initial link_clk = 1'b0;
	always #3 link_clk = !link_clk;
	csrs_top i_dut (.mclk(mclk), .resetn(resetn), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe(sda_oe), .cascade_clock_out(cas_clk), .lower_cascade_data_out(cas_dat),
		.lower_cascade_data_in(cas_in), .discharge_settings(dis_q), .charge_settings(chg_q),
		.feature_settings(fea_q), .config_write_unlock(unl_q), .config_update(cfg_upd));
	csrs_bus_master i_master (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] rnd();
		logic [31:0] r;
		r = $random(seed);
		return r[7:0];
	endfunction
	function automatic logic [7:0] new_val(input logic [3:0] a, input logic [7:0] d);
		logic ok;
		ok = 1'b1;
		if (a == ADDR_DISCHARGE) ok = exp_reg[ADDR_UNLOCK][BIT_DISCHARGE_UNLOCK];
		if (a == ADDR_CHARGE) ok = exp_reg[ADDR_UNLOCK][BIT_CHARGE_UNLOCK];
		if (a == ADDR_FEATURE) ok = exp_reg[ADDR_UNLOCK][BIT_FEATURE_UNLOCK];
		return ok ? d : exp_reg[a];
	endfunction
	function automatic logic [3:0] step(input logic [3:0] p);
		return (p == REG_LAST) ? 4'h0 : p + 4'h1;
	endfunction
	// Addressed burst write of the queued bytes
	task automatic wr(input logic [3:0] a);
		i_master.start();
		i_master.wbyte({SLAVE_LOWER, 1'b0}, ack);
		check("slave ack", {7'h0, ack}, 8'h01);
		i_master.wbyte({4'h0, a}, ack);
		check("addr ack", {7'h0, ack}, 8'h01);
		ptr = a;
		foreach (wq[i]) begin
			i_master.wbyte(wq[i], ack);
			check("data ack", {7'h0, ack}, 8'h01);
			if (ptr <= REG_LAST) exp_reg[ptr] = new_val(ptr, wq[i]);
			ptr = step(ptr);
		end
		i_master.stop();
		wq.delete();
	endtask
	task automatic rd(input logic [3:0] a, input int n, input logic cur, input logic tail);
		logic [7:0] d;
		i_master.start();
		if (!cur) begin
			i_master.wbyte({SLAVE_LOWER, 1'b0}, ack);
			i_master.wbyte({4'h0, a}, ack);
			ptr = a;
			i_master.start();
		end
		i_master.wbyte({SLAVE_LOWER, 1'b1}, ack);
		check("read slave ack", {7'h0, ack}, 8'h01);
		for (int i = 0; i < n; i++) begin
			i_master.rbyte(i == n - 1, d);
			check("read data", d, (ptr <= REG_LAST) ? exp_reg[ptr] : 8'h00);
			ptr = step(ptr);
		end
		if (tail) begin
			i_master.rbyte(1'b1, d);
			check("after nack", d, 8'hFF);
		end
		i_master.stop();
	endtask
	task automatic check_cfg();
		logic [31:0] now_cfg;
		now_cfg = {exp_reg[5], exp_reg[6], exp_reg[7], exp_reg[8]};
		repeat (12) @(posedge mclk);
		check("discharge out", dis_q, exp_reg[5]);
		check("charge out", chg_q, exp_reg[6]);
		check("feature out", fea_q, exp_reg[7]);
		check("unlock out", unl_q, exp_reg[8]);
		check("update pulse", {7'h0, n_upd != upd_mark}, {7'h0, now_cfg != cfg_mark});
		cfg_mark = now_cfg;
		upd_mark = n_upd;
	endtask
	always @(negedge mclk) begin
		check("relay clock", {7'h0, cas_clk}, {7'h0, scl});
		check("relay data", {7'h0, cas_dat}, {7'h0, sda});
		if (cfg_upd === 1'b1) n_upd++;
	end
	initial begin
		repeat (30000) @(posedge mclk);
		n_errors++;
		finish_test();
	end
	initial begin
		seed = 32'h8EAF;
		resetn = 1'b0;
		cas_in = 1'b1;
		n_errors = 0;
		cmp_count = 0;
		cfg_mark = '0;
		upd_mark = 0;
		ptr = 4'h0;
		foreach (exp_reg[i]) exp_reg[i] = 8'h00;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		check_cfg();
		rd(4'h0, 1, 1'b1, 1'b0);
		$display("test reset done");
		repeat (3) wq.push_back(rnd());
		wr(ADDR_DISCHARGE);
		rd(ADDR_DISCHARGE, 3, 1'b0, 1'b0);
		check_cfg();
		$display("test protect done");
		foreach (pat[k]) begin
			wq.push_back(pat[k] | (rnd() & 8'h1F));
			wr(ADDR_UNLOCK);
			repeat (3) wq.push_back(rnd());
			wr(ADDR_DISCHARGE);
			rd(ADDR_DISCHARGE, 4, 1'b0, 1'b0);
			check_cfg();
		end
		$display("test unlock done");
		repeat (5) wq.push_back(rnd());
		wr(4'h9);
		rd(4'h9, 3, 1'b0, 1'b0);
		rd(4'h0, 2, 1'b1, 1'b1);
		$display("test wrap done");
		i_master.start();
		i_master.wbyte({SLAVE_UPPER, 1'b0}, ack);
		check("foreign ack", {7'h0, ack}, 8'h00);
		i_master.wbyte(8'h03, ack);
		check("ignored ack", {7'h0, ack}, 8'h00);
		i_master.stop();
		rd(4'h0, 1, 1'b1, 1'b0);
		$display("test foreign done");
		wq.push_back(rnd());
		wr(4'hC);
		rd(4'hC, 1, 1'b0, 1'b0);
		$display("test range done");
		resetn <= 1'b0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		foreach (exp_reg[i]) exp_reg[i] = 8'h00;
		ptr = 4'h0;
		cfg_mark = '0;
		upd_mark = n_upd;
		check_cfg();
		wq.push_back(rnd());
		wr(ADDR_FEATURE);
		rd(ADDR_FEATURE, 2, 1'b0, 1'b0);
		check_cfg();
		$display("test second reset done");
		cas_in <= 1'b0;
		repeat (4) @(posedge mclk);
		check("upper pull", {7'h0, sda_oe}, 8'h01);
		cas_in <= 1'b1;
		repeat (4) @(posedge mclk);
		check("upper release", {7'h0, sda_oe}, 8'h00);
		$display("test cascade done");
		finish_test();
	end
endmodule
